// ===== bench/pdla_chk.sv
`timescale 1ns/1ps
// ****************************************
// Checker on the top module ports.
// ****************************************
module pdla_chk #(
    parameter OSC_SETTLE_CYCLES = 16,
    parameter ALIGN_CYCLES = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire por_n,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire bypass_system_clock,
    input wire bypass_clock_on_flag,
    input wire load_busy_flag,
    input wire osc_stable,
    input wire [2:0] ratio_adopt,
    input wire [2:0] align_active
);
    reg [7:0] busy_cnt;
    reg [7:0] por_cnt;
    // Counts busy cycles of the running load sequence.
    always @(posedge aclk) begin
        busy_cnt <= (!aresetn || !load_busy_flag) ? 8'h00 : busy_cnt + 8'h01;
    end
    // Counts cycles since power-on reset went away, saturating.
    always @(posedge aclk) begin
        por_cnt <= !por_n ? 8'h00 : (&por_cnt ? por_cnt : por_cnt + 8'h01);
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_busy_length: assert property ($fell(load_busy_flag) |->
        busy_cnt == ALIGN_CYCLES + 1) else $error("busy length wrong");
    a_busy_trigger: assert property ($rose(load_busy_flag) |->
        $rose(s_axi_bvalid)) else $error("busy without write");
    a_adopt_when: assert property (|ratio_adopt |->
        $past(load_busy_flag) && !$past(load_busy_flag, 2))
        else $error("adopt at wrong time");
    a_adopt_pulse: assert property (|ratio_adopt |=> ratio_adopt == 3'h0)
        else $error("adopt too long");
    a_align_in_load: assert property (align_active != 3'h0 |->
        load_busy_flag) else $error("align outside load");
    a_bypass_off: assert property (!bypass_clock_on_flag &&
        !$past(bypass_clock_on_flag) |-> !bypass_system_clock)
        else $error("bypass runs while off");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    a_stable_early: assert property (osc_stable |->
        por_cnt >= OSC_SETTLE_CYCLES - 1) else $error("stable too early");
    a_stable_late: assert property (por_cnt > OSC_SETTLE_CYCLES + 1 |->
        osc_stable) else $error("stable too late");
endmodule

// ===== bench/test_pll_divider_load_and_align.sv
`timescale 1ns/1ps
`include "pdla_map.vh"
module test_pll_divider_load_and_align;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg por_n = 1'b0;
    reg [7:0] awaddr = 8'h00;
    reg awvalid = 1'b0;
    reg [31:0] wdata = 32'h0;
    reg wvalid = 1'b0;
    reg bready = 1'b0;
    reg [7:0] araddr = 8'h00;
    reg arvalid = 1'b0;
    reg rready = 1'b0;
    reg ref_clk = 1'b0;
    reg [1:0] ref_div = 2'h0;
    reg [2:0] ratio_written = 3'h0;
    reg [2:0] seen_adopt = 3'h0;
    reg [2:0] seen_align = 3'h0;
    reg [31:0] rd;
    reg [31:0] rd2;
    reg [1:0] rs;
    reg [31:0] cfg [0:3];
    integer n_errors = 0;
    integer compares = 0;
    integer i;
    integer r;
    wire awready, wready, bvalid, arready, rvalid, bp_clk, on_flag, busy;
    wire stable;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [31:0] rdata2;
    wire [2:0] adopt, align;
    pdla_top #(.PRIMARY(1), .OSC_SETTLE_CYCLES(6), .ALIGN_CYCLES(16))
    pdla_top_inst (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .reference_input_clock(ref_clk), .ratio_written(ratio_written),
        .bypass_system_clock(bp_clk), .bypass_clock_on_flag(on_flag),
        .load_busy_flag(busy), .osc_stable(stable), .ratio_adopt(adopt),
        .align_active(align));
    // Secondary instance shares the bus and answers with the same timing.
    pdla_top #(.PRIMARY(0), .OSC_SETTLE_CYCLES(6), .ALIGN_CYCLES(16))
    pdla_top_inst2 (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(),
        .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(), .s_axi_rdata(rdata2), .s_axi_rresp(),
        .s_axi_rvalid(), .s_axi_rready(rready),
        .reference_input_clock(ref_clk), .ratio_written(ratio_written),
        .bypass_system_clock(), .bypass_clock_on_flag(),
        .load_busy_flag(), .osc_stable(), .ratio_adopt(),
        .align_active());
    // Clock and a reference input eight clock cycles long.
    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        ref_div <= ref_div + 2'h1;
        ref_clk <= (ref_div == 2'h3) ? ~ref_clk : ref_clk;
        seen_adopt <= (|adopt) ? adopt : seen_adopt;
        seen_align <= (|align) ? align : seen_align;
    end
    task report_and_stop;
        begin
            if (n_errors == 0 && compares > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask
    task check(input string name, input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("BAD %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    // Write address and data offered together, each dropped when taken.
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do begin
                @(posedge aclk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (!bvalid);
            rs = bresp;
            bready <= 1'b0;
        end
    endtask
    task rd_chk(input [7:0] a, input [31:0] e, input [1:0] er);
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do begin
                @(posedge aclk);
                if (arready) arvalid <= 1'b0;
            end while (!rvalid);
            rd = rdata;
            rd2 = rdata2;
            rready <= 1'b0;
            check("rdata", rd, e);
            check("rresp", {30'h0, rresp}, {30'h0, er});
        end
    endtask
    // Counts bypass rising edges over a number of reference rising edges.
    task count_bp(input integer edges, output integer rises);
        integer k;
        reg rp;
        reg bp;
        begin
            rises = 0;
            k = 0;
            rp = ref_clk;
            bp = bp_clk;
            while (k < edges) begin
                @(posedge aclk);
                if (ref_clk && !rp) k = k + 1;
                if (bp_clk === 1'b1 && bp === 1'b0) rises = rises + 1;
                rp = ref_clk;
                bp = bp_clk;
            end
        end
    endtask
    // Watchdog against a hung handshake.
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors = n_errors + 1;
        report_and_stop;
    end
    initial begin
        cfg[0] = 32'h00008000;
        cfg[1] = 32'h00008002;
        cfg[2] = 32'h00008003;
        cfg[3] = 32'h00000002;
        @(posedge aclk);
        por_n <= 1'b1;
        repeat (9) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(`PDLA_OFF_BYPASS_DIVIDER_CTRL, 32'h8000, 2'b00);
        check("rdata2", rd2, 32'h8001);
        rd_chk(`PDLA_OFF_PLL_COMMAND, 32'h0, 2'b00);
        rd_chk(`PDLA_OFF_PLL_STATUS, 32'h4, 2'b00);
        // The align register is never written; it keeps its reset value.
        rd_chk(`PDLA_OFF_CLOCK_ALIGN_CTRL, 32'h1f, 2'b00);
        check("rdata2", rd2, 32'h0);
        rd_chk(`PDLA_OFF_RATIO_CHANGE_STATUS, 32'h0, 2'b00);
        rd_chk(`PDLA_OFF_CLOCK_ON_STATUS, 32'h8, 2'b00);
        rd_chk(8'h18, 32'h0, `PDLA_RESP_SLVERR);
        wr(8'h18, 32'h1);
        check("bresp", {30'h0, rs}, {30'h0, `PDLA_RESP_SLVERR});
        wr(`PDLA_OFF_PLL_STATUS, 32'hffffffff);
        rd_chk(`PDLA_OFF_PLL_STATUS, 32'h4, 2'b00);
        wr(`PDLA_OFF_PLL_COMMAND, 32'h0);
        check("busy", {31'h0, busy}, 32'h0);
        @(posedge aclk);
        ratio_written <= 3'h5;
        @(posedge aclk);
        ratio_written <= 3'h0;
        rd_chk(`PDLA_OFF_RATIO_CHANGE_STATUS, 32'h5, 2'b00);
        check("rdata2", rd2, 32'h1);
        wr(`PDLA_OFF_PLL_COMMAND, 32'h1);
        rd_chk(`PDLA_OFF_PLL_STATUS, 32'h5, 2'b00);
        wr(`PDLA_OFF_PLL_COMMAND, 32'h0);
        check("busy", {31'h0, busy}, 32'h1);
        while (busy !== 1'b0) @(posedge aclk);
        check("adopt", {29'h0, seen_adopt}, 32'h5);
        check("align", {29'h0, seen_align}, 32'h7);
        rd_chk(`PDLA_OFF_RATIO_CHANGE_STATUS, 32'h0, 2'b00);
        rd_chk(`PDLA_OFF_PLL_STATUS, 32'h4, 2'b00);
        for (i = 0; i < 4; i = i + 1) begin
            wr(`PDLA_OFF_BYPASS_DIVIDER_CTRL, cfg[i]);
            rd_chk(`PDLA_OFF_BYPASS_DIVIDER_CTRL, cfg[i], 2'b00);
            count_bp(8, r);
            count_bp(24, r);
            check("rises", r, cfg[i][15] ? 24 / (cfg[i][4:0] + 1) : 0);
            rd_chk(`PDLA_OFF_CLOCK_ON_STATUS, {cfg[i][15], 3'h0}, 2'b00);
        end
        report_and_stop;
    end
endmodule
bind pdla_top pdla_chk #(.OSC_SETTLE_CYCLES(OSC_SETTLE_CYCLES),
    .ALIGN_CYCLES(ALIGN_CYCLES)) pdla_chk_inst (.aclk(aclk),
    .aresetn(aresetn), .por_n(por_n), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .bypass_system_clock(bypass_system_clock),
    .bypass_clock_on_flag(bypass_clock_on_flag),
    .load_busy_flag(load_busy_flag), .osc_stable(osc_stable),
    .ratio_adopt(ratio_adopt), .align_active(align_active));

// ===== rtl/pdla_map.vh
`ifndef PDLA_MAP_VH
`define PDLA_MAP_VH

// ********************************************************
// Register byte offsets.
// ********************************************************
`define PDLA_OFF_BYPASS_DIVIDER_CTRL 8'h00
`define PDLA_OFF_PLL_COMMAND 8'h04
`define PDLA_OFF_PLL_STATUS 8'h08
`define PDLA_OFF_CLOCK_ALIGN_CTRL 8'h0c
`define PDLA_OFF_RATIO_CHANGE_STATUS 8'h10
`define PDLA_OFF_CLOCK_ON_STATUS 8'h14

// ********************************************************
// Field positions.
// ********************************************************
`define PDLA_BIT_BYPASS_DIV_ENABLE 15
`define PDLA_RATIO_MSB 4
`define PDLA_BIT_RATIO_LOAD_TRIGGER 0
`define PDLA_BIT_LOAD_BUSY 0
`define PDLA_BIT_OSC_STABLE 2
`define PDLA_BIT_BYPASS_CLOCK_ON 3

// ********************************************************
// Reset values for the two controller instances.
// ********************************************************
`define PDLA_RST_BYPASS_ENABLE 1'b1
`define PDLA_RST_RATIO_PRIMARY 5'h00
`define PDLA_RST_RATIO_SECONDARY 5'h01
`define PDLA_RST_ALIGN_PRIMARY 3'h7
`define PDLA_RST_ALIGN_SECONDARY 3'h0
`define PDLA_RSVD_ALIGN_PRIMARY 29'h0000003
`define PDLA_RSVD_ALIGN_SECONDARY 29'h0000000

// ********************************************************
// Timing counts in clock cycles.
// ********************************************************
`define PDLA_OSC_SETTLE_CYCLES 256
`define PDLA_ALIGN_CYCLES 8

// ********************************************************
// Bus responses.
// ********************************************************
`define PDLA_RESP_OKAY 2'b00
`define PDLA_RESP_SLVERR 2'b10

`endif

// ===== rtl/pdla_top.v
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - Bypass divider runs only when enabled.
// - Bypass divides reference by ratio plus one.
// - Bypass ratio resets 0 primary, 1 secondary.
// - Writing one to trigger starts load.
// - Writing zero to trigger clears the command bit only; a running load continues.
// - Load transfers ratios and aligns clocks.
// - Busy flag reads one during load.
// - Stable flag sets when settling count ends.
// - Settling count finishes during device reset.
// - Align bits select clocks one to three.
// - Align bits reset one primary, zero secondary.
// - Changed flags show modified clock ratios.
// - Secondary third changed flag reads zero.
// - Bypass on flag follows divider running.
`include "pdla_map.vh"

module pdla_top #(
    parameter PRIMARY = 1,
    parameter OSC_SETTLE_CYCLES = `PDLA_OSC_SETTLE_CYCLES,
    parameter ALIGN_CYCLES = `PDLA_ALIGN_CYCLES
) (
    input wire aclk,
    input wire aresetn,
    input wire por_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire reference_input_clock,
    input wire [2:0] ratio_written,
    output reg bypass_system_clock,
    output reg bypass_clock_on_flag,
    output reg load_busy_flag,
    output reg osc_stable,
    output reg [2:0] ratio_adopt,
    output reg [2:0] align_active
);

    // ********************************************************
    // Constants.
    // ********************************************************
    localparam [4:0] RST_RATIO = (PRIMARY != 0) ?
        `PDLA_RST_RATIO_PRIMARY : `PDLA_RST_RATIO_SECONDARY;
    localparam [2:0] RST_ALIGN = (PRIMARY != 0) ?
        `PDLA_RST_ALIGN_PRIMARY : `PDLA_RST_ALIGN_SECONDARY;
    localparam [28:0] RSVD_ALIGN = (PRIMARY != 0) ?
        `PDLA_RSVD_ALIGN_PRIMARY : `PDLA_RSVD_ALIGN_SECONDARY;
    // The secondary instance has no third system clock.
    localparam [2:0] CLK_MASK = (PRIMARY != 0) ? 3'h7 : 3'h3;
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_LOAD = 3'b010;
    localparam [2:0] ST_ALIGN = 3'b100;
    localparam integer SETTLE_LAST_W = OSC_SETTLE_CYCLES - 1;
    localparam integer ALIGN_LAST_W = ALIGN_CYCLES - 1;
    localparam [15:0] SETTLE_LAST = SETTLE_LAST_W[15:0];
    localparam [15:0] ALIGN_LAST = ALIGN_LAST_W[15:0];

    // ********************************************************
    // Register state.
    // ********************************************************
    reg bypass_div_enable;
    reg [4:0] bypass_ratio;
    reg ratio_load_trigger;
    reg [2:0] align_select;
    reg [2:0] ratio_changed;
    reg [2:0] state;
    reg [2:0] load_mask;
    reg [15:0] align_cnt;
    reg [15:0] settle_cnt;
    reg [4:0] bypass_cnt;
    reg ref_meta;
    reg ref_sync;
    reg ref_prev;
    reg aw_held;
    reg w_held;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [31:0] next_rdata;
    reg next_rmapped;
    wire wr_fire;
    wire trigger_write;
    wire ref_rise;
    wire seq_done;

    // ********************************************************
    // Write channel capture, address and data in either order.
    // ********************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
            // Ready is offered for one cycle, then waits for the hold.
            s_axi_awready <= !aw_held && !s_axi_awready &&
                !s_axi_bvalid && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready &&
                !s_axi_bvalid && s_axi_wvalid;
        end
    end

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign trigger_write = wr_fire && w_strb[0] &&
        (aw_addr == `PDLA_OFF_PLL_COMMAND) &&
        w_data[`PDLA_BIT_RATIO_LOAD_TRIGGER];

    // ********************************************************
    // Write response and register updates.
    // ********************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PDLA_RESP_OKAY;
            bypass_div_enable <= `PDLA_RST_BYPASS_ENABLE;
            bypass_ratio <= RST_RATIO;
            align_select <= RST_ALIGN;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    `PDLA_OFF_BYPASS_DIVIDER_CTRL,
                    `PDLA_OFF_PLL_COMMAND,
                    `PDLA_OFF_PLL_STATUS,
                    `PDLA_OFF_CLOCK_ALIGN_CTRL,
                    `PDLA_OFF_RATIO_CHANGE_STATUS,
                    `PDLA_OFF_CLOCK_ON_STATUS: begin
                        s_axi_bresp <= `PDLA_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `PDLA_RESP_SLVERR;
                    end
                endcase
                if (aw_addr == `PDLA_OFF_BYPASS_DIVIDER_CTRL) begin
                    if (w_strb[0]) begin
                        bypass_ratio <= w_data[`PDLA_RATIO_MSB:0];
                    end
                    if (w_strb[1]) begin
                        bypass_div_enable <=
                            w_data[`PDLA_BIT_BYPASS_DIV_ENABLE];
                    end
                end
                // Upper reserved field is fixed; software leaves it.
                if (aw_addr == `PDLA_OFF_CLOCK_ALIGN_CTRL &&
                        w_strb[0]) begin
                    align_select <= w_data[2:0] & CLK_MASK;
                end
            end
        end
    end

    // ********************************************************
    // Command bit, read back until the sequence finishes or a zero is written to it.
    // ********************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            ratio_load_trigger <= 1'b0;
        end else if (trigger_write) begin
            ratio_load_trigger <= 1'b1;
        end else if (wr_fire && w_strb[0] &&
                aw_addr == `PDLA_OFF_PLL_COMMAND) begin
            ratio_load_trigger <= 1'b0;
        end else if (seq_done) begin
            ratio_load_trigger <= 1'b0;
        end
    end

    // ********************************************************
    // Load and alignment sequence.
    // ********************************************************
    assign seq_done = (state == ST_ALIGN) && (align_cnt == ALIGN_LAST);

    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            load_mask <= 3'h0;
            align_cnt <= 16'h0000;
            load_busy_flag <= 1'b0;
            ratio_adopt <= 3'h0;
            align_active <= 3'h0;
        end else begin
            ratio_adopt <= 3'h0;
            case (state)
                ST_IDLE: begin
                    // A trigger while busy is ignored.
                    if (trigger_write) begin
                        state <= ST_LOAD;
                        load_busy_flag <= 1'b1;
                    end
                end
                ST_LOAD: begin
                    // Pending ratios move into the dividers.
                    load_mask <= ratio_changed;
                    ratio_adopt <= ratio_changed;
                    align_active <= align_select;
                    align_cnt <= 16'h0000;
                    state <= ST_ALIGN;
                end
                ST_ALIGN: begin
                    if (seq_done) begin
                        state <= ST_IDLE;
                        load_busy_flag <= 1'b0;
                        align_active <= 3'h0;
                    end else begin
                        align_cnt <= align_cnt + 16'h0001;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    load_busy_flag <= 1'b0;
                    align_active <= 3'h0;
                end
            endcase
        end
    end

    // ********************************************************
    // Ratio changed flags; a new write wins over the clear.
    // ********************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            ratio_changed <= 3'h0;
        end else begin
            ratio_changed <= ((ratio_changed &
                ~(seq_done ? load_mask : 3'h0)) | ratio_written) &
                CLK_MASK;
        end
    end

    // ********************************************************
    // Oscillator settling counter, cleared only by power-on.
    // ********************************************************
    always @(posedge aclk) begin
        if (!por_n) begin
            settle_cnt <= 16'h0000;
            osc_stable <= 1'b0;
        end else if (settle_cnt == SETTLE_LAST) begin
            osc_stable <= 1'b1;
        end else begin
            settle_cnt <= settle_cnt + 16'h0001;
        end
    end

    // ********************************************************
    // Reference clock synchroniser and bypass divider.
    // ********************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            ref_meta <= 1'b0;
            ref_sync <= 1'b0;
            ref_prev <= 1'b0;
        end else begin
            ref_meta <= reference_input_clock;
            ref_sync <= ref_meta;
            ref_prev <= ref_sync;
        end
    end

    assign ref_rise = ref_sync && !ref_prev;

    // Output is high for the first half of each ratio+1 period.
    always @(posedge aclk) begin
        if (!aresetn) begin
            bypass_cnt <= 5'h00;
            bypass_system_clock <= 1'b0;
            bypass_clock_on_flag <= 1'b0;
        end else begin
            bypass_clock_on_flag <= bypass_div_enable;
            if (!bypass_div_enable) begin
                bypass_cnt <= 5'h00;
                bypass_system_clock <= 1'b0;
            end else if (bypass_ratio == 5'h00) begin
                bypass_system_clock <= ref_sync;
            end else if (ref_rise) begin
                if (bypass_cnt >= bypass_ratio) begin
                    bypass_cnt <= 5'h00;
                end else begin
                    bypass_cnt <= bypass_cnt + 5'h01;
                end
                bypass_system_clock <= (bypass_cnt >= bypass_ratio) ||
                    ({1'b0, bypass_cnt} + 6'h01 <
                    ({1'b0, bypass_ratio} + 6'h02) >> 1);
            end
        end
    end

    // ********************************************************
    // Read decode.
    // ********************************************************
    always @* begin
        next_rdata = 32'h00000000;
        next_rmapped = 1'b1;
        case (s_axi_araddr)
            `PDLA_OFF_BYPASS_DIVIDER_CTRL: begin
                next_rdata[`PDLA_BIT_BYPASS_DIV_ENABLE] =
                    bypass_div_enable;
                next_rdata[`PDLA_RATIO_MSB:0] = bypass_ratio;
            end
            `PDLA_OFF_PLL_COMMAND: begin
                next_rdata[`PDLA_BIT_RATIO_LOAD_TRIGGER] =
                    ratio_load_trigger;
            end
            `PDLA_OFF_PLL_STATUS: begin
                next_rdata[`PDLA_BIT_LOAD_BUSY] = load_busy_flag;
                next_rdata[`PDLA_BIT_OSC_STABLE] = osc_stable;
            end
            `PDLA_OFF_CLOCK_ALIGN_CTRL: begin
                next_rdata = {RSVD_ALIGN, align_select};
            end
            `PDLA_OFF_RATIO_CHANGE_STATUS: begin
                next_rdata[2:0] = ratio_changed;
            end
            `PDLA_OFF_CLOCK_ON_STATUS: begin
                next_rdata[`PDLA_BIT_BYPASS_CLOCK_ON] =
                    bypass_clock_on_flag;
            end
            default: begin
                next_rmapped = 1'b0;
            end
        endcase
    end

    // ********************************************************
    // Read channel.
    // ********************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PDLA_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
                s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rmapped ? `PDLA_RESP_OKAY :
                    `PDLA_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule
